// *** rtl/imr_router.sv ***
// interrupt routing, sample-ready generation and mode decode for a six-axis sensor
// assumes an Avalon-MM master on clk; event sources arrive as inputs synchronous to clk
`timescale 1ns/1ps
`include "imr_defs.svh"
// Summary of operation
// R1 - two push-pull interrupt pins, low after reset until a source asserts them
// R2 - motion-wake mode stops samples and pins follow the motion-wake configuration
// R3 - several sources on one pin are combined by logical OR
// R4 - sensor enable bit 7 selects locked-sample mode, zero selects non-locked map
// R5 - locked mode routes command handshake completion to pin A
// R6 - locked mode routes every enabled motion event to pin A
// R7 - locked mode disables the queue and routes sample-ready to pin B
// R8 - non-locked mode mirrors pin A in status bit 1, pin B in bit 0
// R9 - non-locked with routing bit 7 clear shows handshake on pin A, else polled
// R10 - non-locked motion events go to pin A when bit 6 set, else pin B
// R11 - low five routing bits enable the five motion engines
// R12 - bypass queue mode enables sample-ready, other modes enable queuing instead
// R13 - queue interrupt goes to pin A when serial power bit 2 set, else B
// R14 - sample-ready reaches pin B only while the sample-ready mask is zero
// R15 - data updates once per period while low, then one ready pulse rises
// R16 - ready pulse clears itself after a width set by the enabled sensors
// R17 - host reads data while pin B pulse is still high
// R18 - locked mode keeps data registers stable once locked
// R19 - reset gives all sensors off, power-down clear, enables clear, rate zero
// R20 - accel rate pattern 11xx selects the slow clock for low-power operation
// R21 - power-down stops both sensors and sample updates but keeps registers and the bus alive
// R22 - gyro snooze with gyro enable keeps drive but produces no gyro data
// R23 - command completion sets done flag; host writes 0x00 and flag clears
// R24 - watermark flag set at or above nonzero watermark, cleared below it
// R25 - pin routing recomputed every cycle from current mode and bits
module imr_router #(
	parameter int RATE_DIV_BASE = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [4:0] motion_events,
	input wire logic motion_wake_irq,
	input wire logic queue_irq,
	input wire logic [1:0] queue_mode,
	input wire logic [7:0] queue_level,
	input wire logic [7:0] queue_watermark_level,
	output logic irq_pin_a,
	output logic irq_pin_a_oe,
	output logic irq_pin_b,
	output logic irq_pin_b_oe,
	output logic sample_update,
	output logic queue_watermark_flag,
	output logic slow_clock_select,
	output logic [4:0] power_state
);
	logic [7:0] serial_power_control_reg;
	logic [7:0] accel_setup_control_reg;
	logic [7:0] gyro_setup_control_reg;
	logic [7:0] sensor_enable_control_reg;
	logic [7:0] event_routing_control_reg;
	logic [7:0] command_handshake_reg;
	logic command_done_flag_reg;
	imr_pkg::imr_cmd_e cmd_state_reg;
	logic [7:0] cmd_count_reg;
	logic [15:0] rate_count_reg;
	logic [15:0] pulse_count_reg;
	logic ready_level_reg;
	logic [31:0] readdata_reg;
	logic wait_reg;
	logic irq_a_reg;
	logic irq_b_reg;
	logic update_reg;
	logic wtm_reg;
	logic slow_reg;
	logic [4:0] mode_reg;
	logic data_locked_reg;

	// waitrequest is low for exactly one cycle of each request
	wire bus_req = (avs_read | avs_write) & wait_reg;
	wire bus_wr = avs_write & ~wait_reg;
	wire bus_rd = avs_read & ~wait_reg;
	wire lane0 = avs_byteenable[0];
	wire [7:0] wbyte = avs_writedata[7:0];

	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction

	// mode decode
	wire power_down = serial_power_control_reg[`IMR_BIT_POWER_DOWN]; // R21
	wire accel_en = sensor_enable_control_reg[`IMR_BIT_ACCEL_EN] & ~power_down;
	wire gyro_en = sensor_enable_control_reg[`IMR_BIT_GYRO_EN] & ~power_down;
	wire gyro_snooze = sensor_enable_control_reg[`IMR_BIT_GYRO_SNOOZE];
	wire low_rate = (accel_setup_control_reg[3:2] == 2'b11); // R20
	wire motion_wake_mode = accel_en & ~gyro_en & low_rate & (|event_routing_control_reg[4:0]);
	wire gyro_data = gyro_en & ~gyro_snooze; // R22
	wire any_data = (accel_en | gyro_data) & ~motion_wake_mode; // R2
	wire locked_sample_mode = sensor_enable_control_reg[`IMR_BIT_LOCKED]; // R4
	wire bypass = (queue_mode == 2'b00);
	wire ready_func = locked_sample_mode | bypass; // R7 R12
	wire queue_func = ~locked_sample_mode & ~bypass; // R7 R12
	wire [4:0] engines_on = event_routing_control_reg[4:0]; // R11
	wire motion_any = |(motion_events & engines_on); // R6 R11
	wire ready_ok = ready_func & ~sensor_enable_control_reg[`IMR_BIT_READY_MASK]; // R14
	wire ready_src = ready_level_reg & ready_ok & any_data;
	wire hs_a = locked_sample_mode | ~event_routing_control_reg[`IMR_BIT_HS_POLL]; // R5 R9
	wire motion_a = locked_sample_mode | event_routing_control_reg[`IMR_BIT_MOTION_TO_A]; // R10
	wire queue_a = serial_power_control_reg[`IMR_BIT_QUEUE_TO_A]; // R13
	// sources on one pin combine by OR, recomputed each cycle
	wire route_a = (command_done_flag_reg & hs_a) | (motion_any & motion_a)
		| (queue_irq & queue_func & queue_a); // R3 R25
	wire route_b = ready_src | (motion_any & ~motion_a)
		| (queue_irq & queue_func & ~queue_a); // R3 R25
	wire pin_a_next = motion_wake_mode ? motion_wake_irq : route_a; // R2
	wire pin_b_next = motion_wake_mode ? 1'b0 : route_b; // R2
	wire wtm_next = (queue_watermark_level != 8'h00) && (queue_level >= queue_watermark_level); // R24

	// pulse width doubles when both accel and gyro data run
	wire [15:0] pulse_width = `IMR_PULSE_BASE_CYCLES
		<< ((accel_en & gyro_data) ? 1 : 0); // R16
	wire [15:0] period = 16'(RATE_DIV_BASE) << accel_setup_control_reg[1:0];
	wire rate_wrap = (rate_count_reg >= period - 16'h0001);
	wire hold_data = locked_sample_mode & data_locked_reg; // R18
	wire update_next = rate_wrap & any_data & ~hold_data & ~ready_level_reg; // R15

	wire [7:0] status_byte = {command_done_flag_reg, 5'h00,
		locked_sample_mode ? 1'b0 : irq_a_reg, locked_sample_mode ? 1'b0 : irq_b_reg}; // R8
	wire [4:0] mode_next = {motion_wake_mode, low_rate & ~power_down, gyro_data,
		gyro_en, accel_en};

	wire ack_write = bus_wr & lane0 & hit(avs_address, `IMR_OFF_COMMAND)
		& (wbyte == `IMR_CMD_ACK);
	wire cmd_write = bus_wr & lane0 & hit(avs_address, `IMR_OFF_COMMAND)
		& (wbyte != `IMR_CMD_ACK);

	wire [31:0] rd_mux = hit(avs_address, `IMR_OFF_SERIAL_POWER) ? {24'h0, serial_power_control_reg}
		: hit(avs_address, `IMR_OFF_ACCEL_SETUP) ? {24'h0, accel_setup_control_reg}
		: hit(avs_address, `IMR_OFF_GYRO_SETUP) ? {24'h0, gyro_setup_control_reg}
		: hit(avs_address, `IMR_OFF_SENSOR_ENABLE) ? {24'h0, sensor_enable_control_reg}
		: hit(avs_address, `IMR_OFF_EVENT_ROUTING) ? {24'h0, event_routing_control_reg}
		: hit(avs_address, `IMR_OFF_COMMAND) ? {24'h0, command_handshake_reg}
		: hit(avs_address, `IMR_OFF_INT_STATUS) ? {24'h0, status_byte}
		: hit(avs_address, `IMR_OFF_EVENT_IN) ? {19'h0, mode_next, wtm_reg, 7'h00}
		: 32'h0000_0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= ~bus_req;
			if (bus_req && avs_read)
				readdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_power_control_reg <= `IMR_RESET_BYTE; // R19
			accel_setup_control_reg <= `IMR_RESET_BYTE; // R19
			gyro_setup_control_reg <= `IMR_RESET_BYTE;
			sensor_enable_control_reg <= `IMR_RESET_BYTE; // R19
			event_routing_control_reg <= `IMR_RESET_BYTE;
			command_handshake_reg <= `IMR_RESET_BYTE;
		end else if (bus_wr && lane0) begin
			if (hit(avs_address, `IMR_OFF_SERIAL_POWER))
				serial_power_control_reg <= wbyte;
			else if (hit(avs_address, `IMR_OFF_ACCEL_SETUP))
				accel_setup_control_reg <= wbyte;
			else if (hit(avs_address, `IMR_OFF_GYRO_SETUP))
				gyro_setup_control_reg <= wbyte;
			else if (hit(avs_address, `IMR_OFF_SENSOR_ENABLE))
				sensor_enable_control_reg <= wbyte;
			else if (hit(avs_address, `IMR_OFF_EVENT_ROUTING))
				event_routing_control_reg <= wbyte;
			else if (hit(avs_address, `IMR_OFF_COMMAND))
				command_handshake_reg <= wbyte;
		end
	end

	// command engine: fixed execution delay, then done until acknowledged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_state_reg <= imr_pkg::IMR_CMD_IDLE;
			cmd_count_reg <= 8'h00;
			command_done_flag_reg <= 1'b0;
		end else begin
			case (cmd_state_reg)
			imr_pkg::IMR_CMD_IDLE: begin
				if (cmd_write) begin
					cmd_state_reg <= imr_pkg::IMR_CMD_BUSY;
					cmd_count_reg <= `IMR_CMD_EXEC_CYCLES;
				end
			end
			imr_pkg::IMR_CMD_BUSY: begin
				if (cmd_count_reg == 8'h01) begin
					cmd_state_reg <= imr_pkg::IMR_CMD_DONE;
					command_done_flag_reg <= 1'b1; // R23
				end
				cmd_count_reg <= cmd_count_reg - 8'h01;
			end
			imr_pkg::IMR_CMD_DONE: begin
				if (ack_write) begin
					cmd_state_reg <= imr_pkg::IMR_CMD_IDLE;
					command_done_flag_reg <= 1'b0; // R23
				end
			end
			default: cmd_state_reg <= imr_pkg::IMR_CMD_IDLE;
			endcase
		end
	end

	// output-rate timer and self-clearing ready pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_count_reg <= 16'h0000;
			pulse_count_reg <= 16'h0000;
			ready_level_reg <= 1'b0;
			update_reg <= 1'b0;
			data_locked_reg <= 1'b0;
		end else begin
			update_reg <= update_next; // R15
			rate_count_reg <= (rate_wrap || !any_data) ? 16'h0000 : rate_count_reg + 16'h0001;
			if (update_reg) begin
				ready_level_reg <= 1'b1; // R15
				pulse_count_reg <= pulse_width;
			end else if (ready_level_reg) begin
				pulse_count_reg <= pulse_count_reg - 16'h0001;
				if (pulse_count_reg <= 16'h0001)
					ready_level_reg <= 1'b0; // R16
			end
			if (!locked_sample_mode)
				data_locked_reg <= 1'b0;
			else if (update_reg)
				data_locked_reg <= 1'b1; // R18
			else if (bus_rd && hit(avs_address, `IMR_OFF_INT_STATUS))
				data_locked_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_a_reg <= 1'b0; // R1
			irq_b_reg <= 1'b0; // R1
			wtm_reg <= 1'b0;
			slow_reg <= 1'b0;
			mode_reg <= 5'h00;
		end else begin
			irq_a_reg <= pin_a_next; // R25
			irq_b_reg <= pin_b_next; // R25
			wtm_reg <= wtm_next; // R24
			slow_reg <= low_rate & ~power_down; // R20
			mode_reg <= mode_next;
		end
	end

	assign avs_readdata = readdata_reg;
	assign avs_waitrequest = wait_reg;
	assign irq_pin_a = irq_a_reg;
	assign irq_pin_b = irq_b_reg;
	assign irq_pin_a_oe = 1'b1; // R1
	assign irq_pin_b_oe = 1'b1; // R1
	assign sample_update = update_reg;
	assign queue_watermark_flag = wtm_reg;
	assign slow_clock_select = slow_reg;
	assign power_state = mode_reg;

	a_done_on_pin_a: assert property (@(posedge clk) disable iff (rst) // R9
		(command_done_flag_reg && !locked_sample_mode && !event_routing_control_reg[7]
		&& !motion_wake_mode) |=> irq_pin_a)
		else $error("handshake not seen on pin a");
	a_ack_clears_done: assert property (@(posedge clk) disable iff (rst) // R23
		(ack_write && cmd_state_reg == imr_pkg::IMR_CMD_DONE) |=> !command_done_flag_reg)
		else $error("ack did not clear done flag");
	a_pulse_self_clear: assert property (@(posedge clk) disable iff (rst) // R16
		$rose(ready_level_reg) |-> ##[1:40] !ready_level_reg)
		else $error("ready pulse did not clear");
	a_update_while_low: assert property (@(posedge clk) disable iff (rst) // R15
		update_reg |-> !ready_level_reg ##1 ready_level_reg)
		else $error("update not followed by rising ready");
	a_status_mirror: assert property (@(posedge clk) disable iff (rst) // R8
		(avs_read && avs_waitrequest && hit(avs_address, `IMR_OFF_INT_STATUS)
		&& !locked_sample_mode) |=> avs_readdata[1:0] == {$past(irq_pin_a), $past(irq_pin_b)})
		else $error("status does not mirror pins");
	a_mask_blocks: assert property (@(posedge clk) disable iff (rst) // R14
		($past(sensor_enable_control_reg[5]) && !$past(motion_any) && !$past(queue_irq))
		|-> !irq_pin_b)
		else $error("masked ready reached pin b");
	a_locked_motion_a: assert property (@(posedge clk) disable iff (rst) // R6
		(locked_sample_mode && motion_any && !motion_wake_mode) |=> irq_pin_a)
		else $error("locked motion missing on pin a");
	a_wtm_level: assert property (@(posedge clk) disable iff (rst) // R24
		(queue_watermark_level == 8'h00) |=> !queue_watermark_flag)
		else $error("watermark flag with zero watermark");
	a_one_cycle_wait: assert property (@(posedge clk) disable iff (rst)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
		else $error("waitrequest not released");
	a_wake_pin_b: assert property (@(posedge clk) disable iff (rst) // R2
		motion_wake_mode |=> !irq_pin_b)
		else $error("pin b active in motion wake");
	a_wake_follows: assert property (@(posedge clk) disable iff (rst) // R2
		motion_wake_mode |=> (irq_pin_a == $past(motion_wake_irq)))
		else $error("pin a does not follow wake source");
	a_wake_no_update: assert property (@(posedge clk) disable iff (rst) // R2
		motion_wake_mode |=> !sample_update)
		else $error("sample update in motion wake");
	a_queue_to_a: assert property (@(posedge clk) disable iff (rst) // R13
		(queue_irq && queue_func && queue_a && !motion_wake_mode) |=> irq_pin_a)
		else $error("queue interrupt missing on pin a");
	a_queue_to_b: assert property (@(posedge clk) disable iff (rst) // R13
		(queue_irq && queue_func && !queue_a && !motion_wake_mode) |=> irq_pin_b)
		else $error("queue interrupt missing on pin b");
	a_motion_to_a: assert property (@(posedge clk) disable iff (rst) // R10
		(!locked_sample_mode && event_routing_control_reg[6] && motion_any
		&& !motion_wake_mode) |=> irq_pin_a)
		else $error("motion event missing on pin a");
	a_motion_to_b: assert property (@(posedge clk) disable iff (rst) // R10
		(!locked_sample_mode && !event_routing_control_reg[6] && motion_any
		&& !motion_wake_mode) |=> irq_pin_b)
		else $error("motion event missing on pin b");
	a_ready_to_b: assert property (@(posedge clk) disable iff (rst) // R14
		(ready_level_reg && ready_func && !sensor_enable_control_reg[5] && any_data
		&& !motion_wake_mode) |=> irq_pin_b)
		else $error("ready pulse missing on pin b");
	a_locked_hs_a: assert property (@(posedge clk) disable iff (rst) // R5
		(locked_sample_mode && command_done_flag_reg && !motion_wake_mode) |=> irq_pin_a)
		else $error("locked handshake missing on pin a");
	a_locked_pin_b: assert property (@(posedge clk) disable iff (rst) // R7
		(locked_sample_mode && !ready_level_reg && !motion_wake_mode) |=> !irq_pin_b)
		else $error("locked pin b shows other than ready");
	a_power_down_quiet: assert property (@(posedge clk) disable iff (rst) // R21
		power_down |=> !sample_update)
		else $error("sample update in power down");
	a_snooze_no_gyro: assert property (@(posedge clk) disable iff (rst) // R22
		gyro_snooze |=> !power_state[2])
		else $error("gyro data while snoozed");
	a_slow_select: assert property (@(posedge clk) disable iff (rst) // R20
		(low_rate && !power_down) |=> slow_clock_select)
		else $error("slow clock not selected");
	a_cmd_done_delay: assert property (@(posedge clk) disable iff (rst) // R23
		(cmd_write && cmd_state_reg == imr_pkg::IMR_CMD_IDLE) |-> ##9 command_done_flag_reg)
		else $error("command done flag late");
	a_wtm_set: assert property (@(posedge clk) disable iff (rst) // R24
		(queue_watermark_level != 8'h00 && queue_level >= queue_watermark_level)
		|=> queue_watermark_flag)
		else $error("watermark flag not set");
endmodule

// *** rtl/imr_defs.svh ***
// register offsets, field positions, reset values and timing counts for the interrupt router
// assumes inclusion by name from the top module and the testbench
`ifndef IMR_DEFS_SVH
`define IMR_DEFS_SVH
`define IMR_OFF_SERIAL_POWER 5'h04
`define IMR_OFF_ACCEL_SETUP 5'h08
`define IMR_OFF_GYRO_SETUP 5'h0c
`define IMR_OFF_SENSOR_ENABLE 5'h10
`define IMR_OFF_EVENT_ROUTING 5'h14
`define IMR_OFF_COMMAND 5'h18
`define IMR_OFF_INT_STATUS 5'h1c
`define IMR_OFF_EVENT_IN 5'h00
`define IMR_BIT_QUEUE_TO_A 2
`define IMR_BIT_POWER_DOWN 0
`define IMR_BIT_LOCKED 7
`define IMR_BIT_READY_MASK 5
`define IMR_BIT_GYRO_SNOOZE 4
`define IMR_BIT_GYRO_EN 1
`define IMR_BIT_ACCEL_EN 0
`define IMR_BIT_HS_POLL 7
`define IMR_BIT_MOTION_TO_A 6
`define IMR_BIT_CMD_DONE 7
`define IMR_CMD_ACK 8'h00
`define IMR_RESET_BYTE 8'h00
`define IMR_CMD_EXEC_CYCLES 8'h08
`define IMR_PULSE_BASE_CYCLES 16'h0010
`define IMR_PERIOD_NS 100
`endif

// *** rtl/imr_pkg.sv ***
// types shared by the interrupt router
// assumes imr_defs.svh is on the include path
package imr_pkg;
	typedef enum logic [1:0] {
		IMR_OFF,
		IMR_LOW_POWER,
		IMR_POWER_DOWN,
		IMR_ACTIVE
	} imr_power_e;
	typedef enum logic [1:0] {
		IMR_CMD_IDLE,
		IMR_CMD_BUSY,
		IMR_CMD_DONE
	} imr_cmd_e;
	typedef struct packed {
		logic accel_on;
		logic gyro_drive;
		logic gyro_data;
		logic low_power;
		logic motion_wake;
	} imr_mode_s;
endpackage

// *** tb/imr_host_model.sv ***
// host-side model: watches pin b for ready pulses and measures them
// assumes pin b is a registered push-pull level on clk
`timescale 1ns/1ps
module imr_host_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_pin_b,
	output int rises,
	output int width,
	output int period
);
	logic b_q;
	int since;
	int hi;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			b_q <= 1'b0;
			rises <= 0;
			width <= 0;
			period <= 0;
			since <= 0;
			hi <= 0;
		end else begin
			b_q <= irq_pin_b;
			since <= since + 1;
			if (irq_pin_b)
				hi <= hi + 1;
			// rising edge means fresh data is ready to read
			if (irq_pin_b && !b_q) begin
				rises <= rises + 1;
				period <= since + 1;
				since <= 0;
				hi <= 1;
			end
			if (!irq_pin_b && b_q)
				width <= hi;
		end
	end
endmodule

// *** tb/test_imu_interrupt_mode_router.sv ***
// self-checking bench for the interrupt router, driven over avalon-mm
// assumes imr_defs.svh on the include path and a 10 MHz clock
`timescale 1ns/1ps
`include "imr_defs.svh"
module test_imu_interrupt_mode_router;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, rv;
	logic wait_req, pin_a, pin_a_oe, pin_b, pin_b_oe, upd, wtm_flag, slow_sel;
	logic [4:0] events = 5'h00;
	logic wake_irq = 1'b0;
	logic q_irq = 1'b0;
	logic [1:0] q_mode = 2'h0;
	logic [7:0] q_level = 8'h00;
	logic [7:0] q_wtm = 8'h00;
	logic [4:0] pstate;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int upd_count = 0;
	int r0, rises, width, period;
	always #50 clk = ~clk;
	imr_router #(.RATE_DIV_BASE(64)) dut (.clk(clk), .rst(rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1),
		.avs_readdata(rdata), .avs_waitrequest(wait_req), .motion_events(events),
		.motion_wake_irq(wake_irq), .queue_irq(q_irq), .queue_mode(q_mode),
		.queue_level(q_level), .queue_watermark_level(q_wtm), .irq_pin_a(pin_a),
		.irq_pin_a_oe(pin_a_oe), .irq_pin_b(pin_b), .irq_pin_b_oe(pin_b_oe),
		.sample_update(upd), .queue_watermark_flag(wtm_flag),
		.slow_clock_select(slow_sel), .power_state(pstate));
	imr_host_model host (.clk(clk), .rst(rst), .irq_pin_b(pin_b), .rises(rises),
		.width(width), .period(period));
	task end_of_test;
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wait_ack;
		@(posedge clk);
		while (wait_req !== 1'b0)
			@(posedge clk);
	endtask
	task bus_wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wdata <= {24'h000000, d};
		wr <= 1'b1;
		wait_ack();
		wr <= 1'b0;
	endtask
	task rchk(input string name, input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		wait_ack();
		rv = rdata;
		rd <= 1'b0;
		chk(name, e, rv & m);
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task drive(input logic [4:0] ev, input logic qi);
		@(posedge clk);
		events <= ev;
		q_irq <= qi;
		settle(3);
	endtask
	task wm(input logic [7:0] l, input logic [7:0] w, input logic e);
		@(posedge clk);
		q_level <= l;
		q_wtm <= w;
		settle(2);
		chk("watermark", e, wtm_flag);
	endtask
	task quiet(input string name);
		settle(2);
		r0 = rises;
		settle(300);
		chk(name, r0, rises);
	endtask
	always @(posedge clk) begin
		if (upd === 1'b1)
			upd_count++;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle(1);
		chk("pins", 2'b00, {pin_a, pin_b});
		chk("oe wait", 3'b111, {pin_a_oe, pin_b_oe, wait_req});
		chk("mode", 6'h00, {slow_sel, pstate});
		rchk("serial", `IMR_OFF_SERIAL_POWER, 32'hff, 32'h0);
		rchk("accel", `IMR_OFF_ACCEL_SETUP, 32'hff, 32'h0);
		rchk("enable", `IMR_OFF_SENSOR_ENABLE, 32'hff, 32'h0);
		rchk("unmapped", 5'h06, 32'hffffffff, 32'h0);
		// mask ready so pin b only shows routed events
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h20);
		bus_wr(`IMR_OFF_EVENT_ROUTING, 8'h41);
		drive(5'h1e, 1'b0);
		chk("gated", 2'b00, {pin_a, pin_b});
		drive(5'h1f, 1'b0);
		chk("motion a", 2'b10, {pin_a, pin_b});
		rchk("status", `IMR_OFF_INT_STATUS, 32'h3, 32'h2);
		bus_wr(`IMR_OFF_EVENT_ROUTING, 8'h01);
		settle(3);
		chk("motion b", 2'b01, {pin_a, pin_b});
		rchk("status", `IMR_OFF_INT_STATUS, 32'h3, 32'h1);
		bus_wr(`IMR_OFF_EVENT_ROUTING, 8'h41);
		q_mode <= 2'h1;
		bus_wr(`IMR_OFF_SERIAL_POWER, 8'h04);
		drive(5'h1f, 1'b1);
		chk("or both", 2'b10, {pin_a, pin_b});
		drive(5'h1f, 1'b0);
		chk("or a", 1'b1, pin_a);
		drive(5'h00, 1'b1);
		chk("queue a", 2'b10, {pin_a, pin_b});
		bus_wr(`IMR_OFF_SERIAL_POWER, 8'h00);
		settle(3);
		chk("queue b", 2'b01, {pin_a, pin_b});
		drive(5'h00, 1'b0);
		bus_wr(`IMR_OFF_COMMAND, 8'h05);
		settle(12);
		chk("done pin", 2'b10, {pin_a, pin_b});
		rchk("done", `IMR_OFF_INT_STATUS, 32'h80, 32'h80);
		bus_wr(`IMR_OFF_COMMAND, `IMR_CMD_ACK);
		settle(3);
		chk("ack pin", 1'b0, pin_a);
		rchk("ack", `IMR_OFF_INT_STATUS, 32'h80, 32'h0);
		bus_wr(`IMR_OFF_EVENT_ROUTING, 8'h81);
		bus_wr(`IMR_OFF_COMMAND, 8'h05);
		settle(12);
		chk("poll pin", 1'b0, pin_a);
		rchk("poll", `IMR_OFF_INT_STATUS, 32'h80, 32'h80);
		bus_wr(`IMR_OFF_COMMAND, `IMR_CMD_ACK);
		// locked map: queue goes nowhere, motion and handshake reach pin a
		bus_wr(`IMR_OFF_SERIAL_POWER, 8'h04);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h81);
		drive(5'h00, 1'b1);
		chk("locked queue", 1'b0, pin_a);
		drive(5'h01, 1'b1);
		chk("locked motion", 1'b1, pin_a);
		drive(5'h00, 1'b0);
		bus_wr(`IMR_OFF_COMMAND, 8'h05);
		settle(12);
		chk("locked done", 1'b1, pin_a);
		bus_wr(`IMR_OFF_COMMAND, `IMR_CMD_ACK);
		// locked data holds after one update until the status read releases it
		r0 = rises;
		settle(200);
		chk("locked hold", r0 + 1, rises);
		rchk("locked status", `IMR_OFF_INT_STATUS, 32'h83, 32'h0);
		settle(200);
		chk("locked ready", r0 + 2, rises);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h01);
		q_mode <= 2'h0;
		r0 = upd_count;
		settle(300);
		chk("updates", 1'b1, upd_count >= r0 + 4);
		chk("width", 16, width);
		chk("period", 64, period);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h03);
		q_mode <= 2'h0;
		bus_wr(`IMR_OFF_ACCEL_SETUP, 8'h01);
		bus_wr(`IMR_OFF_GYRO_SETUP, 8'h01);
		settle(500);
		chk("width", 32, width);
		chk("period", 128, period);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h23);
		quiet("masked");
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h03);
		q_mode <= 2'h2;
		quiet("queued");
		q_mode <= 2'h0;
		bus_wr(`IMR_OFF_SERIAL_POWER, 8'h01);
		quiet("power down");
		rchk("kept", `IMR_OFF_SENSOR_ENABLE, 32'hff, 32'h03);
		bus_wr(`IMR_OFF_SERIAL_POWER, 8'h00);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h33);
		settle(3);
		chk("snooze", 5'h03, pstate);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h23);
		settle(3);
		chk("gyro data", 5'h07, pstate);
		bus_wr(`IMR_OFF_SENSOR_ENABLE, 8'h21);
		bus_wr(`IMR_OFF_ACCEL_SETUP, 8'h0c);
		settle(3);
		chk("slow wake", 6'h39, {slow_sel, pstate});
		r0 = upd_count;
		settle(200);
		chk("wake data", r0, upd_count);
		@(posedge clk);
		wake_irq <= 1'b1;
		settle(3);
		chk("wake pins", 2'b10, {pin_a, pin_b});
		@(posedge clk);
		wake_irq <= 1'b0;
		settle(3);
		chk("wake low", 1'b0, pin_a);
		wm(8'h04, 8'h04, 1'b1);
		wm(8'h03, 8'h04, 1'b0);
		wm(8'h05, 8'h00, 1'b0);
		end_of_test();
	end
endmodule
